/* pkg/pin_mux_params.svh */
// constants for the port alternate-function selector
// assumes inclusion by the design file and the bench only
// What this block does
// RULE1 - p02 with mode bit: select 0 gives nmi input, 1 gives address bit 21
// RULE2 - p03 ext/sel: 00 irq0, 01 adc trigger, 11 rtc one hertz
// RULE3 - p04 ext/sel: 00 irq1 input, 01 rtc divided out, 10 rtc clock out
// RULE4 - p05 irq2 with mode bit; debug reset input whenever debug enable is set
// RULE5 - p06 is irq3 input when its mode bit is set
// RULE6 - p10/p11 carry dac outputs when direction bit set to input
// RULE7 - p30: select 0 uart0 transmit, select 1 serial 4 data out
// RULE8 - p31: select 0 feeds uart0 receive and irq7, 1 feeds serial 4 in
// RULE9 - software disables irq7 edges or uart0 receive depending on pin use
// RULE10 - p32 ext/sel: 00 baud clock, 01 serial 4 clock, 10 timer in, 11 timer out
// RULE11 - p33: select 0 timer p0 capture 1, select 1 timer p0 output 1
// RULE12 - p34/p35: select 0 timer p1 inputs, select 1 timer p1 outputs
// RULE13 - p36/p37 with mode bit carry uart3 transmit and receive
// RULE14 - p38/p39: select 0 uart2, select 1 i2c0 open drain
// RULE15 - p40/p41: select 0 serial 0 in/out, select 1 i2c1 open drain
// RULE16 - p42 carries serial 0 clock in or out with mode bit set
// RULE17 - p50 ext/sel: 01 timer q0 in/key return, 10 timer out, 11 realtime bit
// RULE18 - alternate functions ignore the port latch and direction bits
// RULE19 - keep general port level steady while the other dac pin drives
// RULE20 - mode bit clear and no debug: pin follows port latch and input path
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH
`define NPINS 24
// pin indices in the flat pin vectors
`define PX02 0
`define PX03 1
`define PX04 2
`define PX05 3
`define PX06 4
`define PX10 5
`define PX11 6
`define PX30 7
`define PX31 8
`define PX32 9
`define PX33 10
`define PX34 11
`define PX35 12
`define PX36 13
`define PX37 14
`define PX38 15
`define PX39 16
`define PX40 17
`define PX41 18
`define PX42 19
`define PX50 20
`define RST_PINS 24'h000000
`define RST_DIR 24'hffffff
`endif

/* pkg/pin_mux_pkg.sv */
// types for the port alternate-function selector
// assumes nothing beyond the params header
`default_nettype none
package pin_mux_pkg;
	typedef logic [1:0] sel_pair_t;
	typedef logic [23:0] pin_vec_t;
endpackage
`default_nettype wire

/* src/port_alt_function_select.sv */
// port 0, 1, 3, 4, 5 pin function selector with registered pin drives
// assumes config bits and peripheral signals are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_params.svh"
module port_alt_function_select (
	input  wire logic               clk,
	input  wire logic               nrst,
	input  wire pin_mux_pkg::pin_vec_t pin_function_mode_bit,
	input  wire pin_mux_pkg::pin_vec_t function_select_bit,
	input  wire pin_mux_pkg::pin_vec_t function_select_ext_bit,
	input  wire pin_mux_pkg::pin_vec_t io_direction_bit,
	input  wire pin_mux_pkg::pin_vec_t open_drain_bit,
	input  wire pin_mux_pkg::pin_vec_t port_latch,
	input  wire logic               debug_pin_enable,
	input  wire pin_mux_pkg::pin_vec_t pin_in,
	output logic [23:0]             pin_out,
	output logic [23:0]             pin_oe,
	output logic [23:0]             port_in,
	input  wire logic               addr_bit_21,
	input  wire logic               rtc_one_hertz,
	input  wire logic               rtc_divided_out,
	input  wire logic               rtc_clock_out,
	input  wire logic               dac_out_0,
	input  wire logic               dac_out_1,
	input  wire logic               uart0_tx,
	input  wire logic               csi4_data_out,
	input  wire logic               csi4_clock_out,
	input  wire logic               csi4_clock_oe,
	input  wire logic               timer_p0_out0,
	input  wire logic               timer_p0_out1,
	input  wire logic               timer_p1_out0,
	input  wire logic               timer_p1_out1,
	input  wire logic               uart3_tx,
	input  wire logic               uart2_tx,
	input  wire logic               i2c0_data_drive_low,
	input  wire logic               i2c0_clock_drive_low,
	input  wire logic               i2c1_data_drive_low,
	input  wire logic               i2c1_clock_drive_low,
	input  wire logic               csi0_data_out,
	input  wire logic               csi0_clock_out,
	input  wire logic               csi0_clock_oe,
	input  wire logic               timer_q0_out1,
	input  wire logic               realtime_port_bit0,
	output logic                    nmi_in,
	output logic                    ext_irq_0,
	output logic                    adc_ext_trigger,
	output logic                    ext_irq_1,
	output logic                    ext_irq_2,
	output logic                    debug_reset_in,
	output logic                    ext_irq_3,
	output logic                    uart0_rx,
	output logic                    ext_irq_7,
	output logic                    csi4_data_in,
	output logic                    csi4_clock_in,
	output logic                    uart0_baud_clock_in,
	output logic                    timer_p0_in0,
	output logic                    timer_p0_in1,
	output logic                    timer_p1_in0,
	output logic                    timer_p1_in1,
	output logic                    uart3_rx,
	output logic                    uart2_rx,
	output logic                    i2c0_data_in,
	output logic                    i2c0_clock_in,
	output logic                    i2c1_data_in,
	output logic                    i2c1_clock_in,
	output logic                    csi0_data_in,
	output logic                    csi0_clock_in,
	output logic                    timer_q0_in1,
	output logic                    key_return_0,
	output logic                    dac_active_0,
	output logic                    dac_active_1
);
	import pin_mux_pkg::*;

	// ************************************************************
	// output path selection
	// ************************************************************
	logic [23:0] out_next;
	logic [23:0] oe_next;
	logic [23:0] alt_used;
	logic [23:0] alt_out;
	logic [23:0] alt_oe;
	sel_pair_t   s03;
	sel_pair_t   s04;
	sel_pair_t   s32;
	sel_pair_t   s50;
	logic        od38;
	logic        od39;
	logic        od40;
	logic        od41;

	always_comb begin
		s03 = {function_select_ext_bit[`PX03], function_select_bit[`PX03]};
		s04 = {function_select_ext_bit[`PX04], function_select_bit[`PX04]};
		s32 = {function_select_ext_bit[`PX32], function_select_bit[`PX32]};
		s50 = {function_select_ext_bit[`PX50], function_select_bit[`PX50]};
		od38 = open_drain_bit[`PX38];
		od39 = open_drain_bit[`PX39];
		od40 = open_drain_bit[`PX40];
		od41 = open_drain_bit[`PX41];
		alt_used = pin_function_mode_bit;
		alt_used[`PX05] = pin_function_mode_bit[`PX05] | debug_pin_enable; // RULE4
		alt_used[`PX10] = 1'b0;
		alt_used[`PX11] = 1'b0;
		alt_used[23:21] = 3'h0;
		alt_out = 24'h000000;
		alt_oe = 24'h000000;
		// p05 and p06 are input-only alternates: drivers stay off
		alt_out[`PX02] = addr_bit_21; // RULE1
		alt_oe[`PX02] = function_select_bit[`PX02]; // RULE1
		alt_out[`PX03] = rtc_one_hertz; // RULE2
		alt_oe[`PX03] = (s03 == 2'h3); // RULE2
		if (s04 == 2'h1) begin // RULE3
			alt_out[`PX04] = rtc_divided_out;
			alt_oe[`PX04] = 1'b1;
		end else if (s04 == 2'h2) begin // RULE3
			alt_out[`PX04] = rtc_clock_out;
			alt_oe[`PX04] = 1'b1;
		end
		alt_out[`PX30] = function_select_bit[`PX30] ? csi4_data_out : uart0_tx; // RULE7
		alt_oe[`PX30] = 1'b1;
		if (s32 == 2'h1) begin // RULE10
			alt_out[`PX32] = csi4_clock_out;
			alt_oe[`PX32] = csi4_clock_oe;
		end else if (s32 == 2'h3) begin // RULE10
			alt_out[`PX32] = timer_p0_out0;
			alt_oe[`PX32] = 1'b1;
		end
		alt_out[`PX33] = timer_p0_out1; // RULE11
		alt_oe[`PX33] = function_select_bit[`PX33]; // RULE11
		alt_out[`PX34] = timer_p1_out0; // RULE12
		alt_oe[`PX34] = function_select_bit[`PX34]; // RULE12
		alt_out[`PX35] = timer_p1_out1; // RULE12
		alt_oe[`PX35] = function_select_bit[`PX35]; // RULE12
		alt_out[`PX36] = uart3_tx; // RULE13
		alt_oe[`PX36] = 1'b1;
		// i2c pins only pull low, relying on the open-drain bit being set
		if (function_select_bit[`PX38]) begin // RULE14
			alt_oe[`PX38] = i2c0_data_drive_low | ~od38;
		end else begin
			alt_out[`PX38] = uart2_tx; // RULE14
			alt_oe[`PX38] = 1'b1;
		end
		alt_oe[`PX39] = function_select_bit[`PX39] & (i2c0_clock_drive_low | ~od39); // RULE14
		if (function_select_bit[`PX40]) begin // RULE15
			alt_oe[`PX40] = i2c1_data_drive_low | ~od40;
		end
		if (function_select_bit[`PX41]) begin // RULE15
			alt_oe[`PX41] = i2c1_clock_drive_low | ~od41;
		end else begin
			alt_out[`PX41] = csi0_data_out; // RULE15
			alt_oe[`PX41] = 1'b1;
		end
		alt_out[`PX42] = csi0_clock_out; // RULE16
		alt_oe[`PX42] = csi0_clock_oe;
		if (s50 == 2'h2) begin // RULE17
			alt_out[`PX50] = timer_q0_out1;
			alt_oe[`PX50] = 1'b1;
		end else if (s50 == 2'h3) begin // RULE17
			alt_out[`PX50] = realtime_port_bit0;
			alt_oe[`PX50] = 1'b1;
		end
		for (int i = 0; i < `NPINS; i++) begin
			if (alt_used[i]) begin // RULE18
				out_next[i] = alt_out[i];
				oe_next[i] = alt_oe[i];
			end else begin // RULE20
				out_next[i] = port_latch[i] & ~open_drain_bit[i];
				oe_next[i] = ~io_direction_bit[i] & ~(open_drain_bit[i] & port_latch[i]);
			end
		end
		// dac pins: analog drive replaces the port when direction is input
		out_next[`PX10] = io_direction_bit[`PX10] ? dac_out_0 : port_latch[`PX10]; // RULE6
		oe_next[`PX10] = ~io_direction_bit[`PX10];
		out_next[`PX11] = io_direction_bit[`PX11] ? dac_out_1 : port_latch[`PX11]; // RULE6
		oe_next[`PX11] = ~io_direction_bit[`PX11];
		out_next[23:21] = 3'h0;
		oe_next[23:21] = 3'h0;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_out <= `RST_PINS;
			pin_oe <= `RST_PINS;
			dac_active_0 <= 1'b0;
			dac_active_1 <= 1'b0;
		end else begin
			pin_out <= out_next;
			pin_oe <= oe_next;
			dac_active_0 <= io_direction_bit[`PX10]; // RULE6
			dac_active_1 <= io_direction_bit[`PX11]; // RULE6
		end
	end

	// ************************************************************
	// input routing
	// ************************************************************
	// idle level for an unselected interrupt, trigger, timer or serial input is 0; uart receive and i2c inputs idle at 1
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			port_in <= `RST_PINS;
			nmi_in <= 1'b0;
			ext_irq_0 <= 1'b0;
			adc_ext_trigger <= 1'b0;
			ext_irq_1 <= 1'b0;
			ext_irq_2 <= 1'b0;
			debug_reset_in <= 1'b0;
			ext_irq_3 <= 1'b0;
		end else begin
			port_in <= pin_in & ~alt_used; // RULE20
			nmi_in <= pin_function_mode_bit[`PX02] & ~function_select_bit[`PX02]
				& pin_in[`PX02]; // RULE1
			ext_irq_0 <= pin_function_mode_bit[`PX03] & (s03 == 2'h0) & pin_in[`PX03]; // RULE2
			adc_ext_trigger <= pin_function_mode_bit[`PX03] & (s03 == 2'h1)
				& pin_in[`PX03]; // RULE2
			ext_irq_1 <= pin_function_mode_bit[`PX04] & (s04 == 2'h0) & pin_in[`PX04]; // RULE3
			ext_irq_2 <= pin_function_mode_bit[`PX05] & ~debug_pin_enable
				& pin_in[`PX05]; // RULE4
			debug_reset_in <= debug_pin_enable & pin_in[`PX05]; // RULE4
			ext_irq_3 <= pin_function_mode_bit[`PX06] & pin_in[`PX06]; // RULE5
		end
	end

	logic m31;
	logic m32;
	assign m31 = pin_function_mode_bit[`PX31];
	assign m32 = pin_function_mode_bit[`PX32];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			uart0_rx <= 1'b1;
			ext_irq_7 <= 1'b0;
			csi4_data_in <= 1'b0;
			csi4_clock_in <= 1'b0;
			uart0_baud_clock_in <= 1'b0;
			timer_p0_in0 <= 1'b0;
			timer_p0_in1 <= 1'b0;
			timer_p1_in0 <= 1'b0;
			timer_p1_in1 <= 1'b0;
			uart3_rx <= 1'b1;
			uart2_rx <= 1'b1;
		end else begin
			// both receivers share the pin; software silences the unused one
			uart0_rx <= (m31 & ~function_select_bit[`PX31]) ? pin_in[`PX31] : 1'b1; // RULE8
			ext_irq_7 <= m31 & ~function_select_bit[`PX31] & pin_in[`PX31]; // RULE8
			csi4_data_in <= m31 & function_select_bit[`PX31] & pin_in[`PX31]; // RULE8
			csi4_clock_in <= m32 & (s32 == 2'h1) & pin_in[`PX32]; // RULE10
			uart0_baud_clock_in <= m32 & (s32 == 2'h0) & pin_in[`PX32]; // RULE10
			timer_p0_in0 <= m32 & (s32 == 2'h2) & pin_in[`PX32]; // RULE10
			timer_p0_in1 <= pin_function_mode_bit[`PX33] & ~function_select_bit[`PX33]
				& pin_in[`PX33]; // RULE11
			timer_p1_in0 <= pin_function_mode_bit[`PX34] & ~function_select_bit[`PX34]
				& pin_in[`PX34]; // RULE12
			timer_p1_in1 <= pin_function_mode_bit[`PX35] & ~function_select_bit[`PX35]
				& pin_in[`PX35]; // RULE12
			uart3_rx <= pin_function_mode_bit[`PX37] ? pin_in[`PX37] : 1'b1; // RULE13
			uart2_rx <= (pin_function_mode_bit[`PX39] & ~function_select_bit[`PX39])
				? pin_in[`PX39] : 1'b1; // RULE14
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			i2c0_data_in <= 1'b1;
			i2c0_clock_in <= 1'b1;
			i2c1_data_in <= 1'b1;
			i2c1_clock_in <= 1'b1;
			csi0_data_in <= 1'b0;
			csi0_clock_in <= 1'b0;
			timer_q0_in1 <= 1'b0;
			key_return_0 <= 1'b0;
		end else begin
			i2c0_data_in <= ~(pin_function_mode_bit[`PX38] & function_select_bit[`PX38])
				| pin_in[`PX38]; // RULE14
			i2c0_clock_in <= ~(pin_function_mode_bit[`PX39] & function_select_bit[`PX39])
				| pin_in[`PX39]; // RULE14
			i2c1_data_in <= ~(pin_function_mode_bit[`PX40] & function_select_bit[`PX40])
				| pin_in[`PX40]; // RULE15
			i2c1_clock_in <= ~(pin_function_mode_bit[`PX41] & function_select_bit[`PX41])
				| pin_in[`PX41]; // RULE15
			csi0_data_in <= pin_function_mode_bit[`PX40] & ~function_select_bit[`PX40]
				& pin_in[`PX40]; // RULE15
			csi0_clock_in <= pin_function_mode_bit[`PX42] & pin_in[`PX42]; // RULE16
			timer_q0_in1 <= pin_function_mode_bit[`PX50] & (s50 == 2'h1) & pin_in[`PX50]; // RULE17
			key_return_0 <= pin_function_mode_bit[`PX50] & (s50 == 2'h1) & pin_in[`PX50]; // RULE17
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	a_p30_uart_route: assert property (@(posedge clk) disable iff (!nrst)
		pin_function_mode_bit[`PX30] && !function_select_bit[`PX30]
		|=> pin_out[`PX30] == $past(uart0_tx) && pin_oe[`PX30]) // RULE7
		else $error("p30 not carrying uart0 transmit");
	a_p05_debug_override: assert property (@(posedge clk) disable iff (!nrst)
		debug_pin_enable |=> !ext_irq_2 && debug_reset_in == $past(pin_in[`PX05])) // RULE4
		else $error("p05 debug override broken");
	a_p02_nmi_route: assert property (@(posedge clk) disable iff (!nrst)
		pin_function_mode_bit[`PX02] && !function_select_bit[`PX02]
		|=> nmi_in == $past(pin_in[`PX02])) // RULE1
		else $error("p02 nmi route broken");
	a_p03_trigger_route: assert property (@(posedge clk) disable iff (!nrst)
		pin_function_mode_bit[`PX03] && s03 == 2'h1
		|=> adc_ext_trigger == $past(pin_in[`PX03]) && !ext_irq_0) // RULE2
		else $error("p03 trigger route broken");
	a_p04_rtc_clock: assert property (@(posedge clk) disable iff (!nrst)
		pin_function_mode_bit[`PX04] && s04 == 2'h2
		|=> pin_out[`PX04] == $past(rtc_clock_out) && pin_oe[`PX04]) // RULE3
		else $error("p04 rtc clock route broken");
	a_p32_timer_out: assert property (@(posedge clk) disable iff (!nrst)
		m32 && s32 == 2'h3 |=> pin_out[`PX32] == $past(timer_p0_out0)) // RULE10
		else $error("p32 timer output route broken");
	a_p31_shared_rx: assert property (@(posedge clk) disable iff (!nrst)
		m31 && !function_select_bit[`PX31]
		|=> uart0_rx == ext_irq_7 && !csi4_data_in) // RULE8
		else $error("p31 shared receive broken");
	a_latch_ignored: assert property (@(posedge clk) disable iff (!nrst)
		pin_function_mode_bit[`PX36] && $stable(uart3_tx) && $changed(port_latch[`PX36])
		|=> pin_out[`PX36] == $past(uart3_tx)) // RULE18
		else $error("port latch leaks into alternate output");
	a_port_default: assert property (@(posedge clk) disable iff (!nrst)
		!pin_function_mode_bit[`PX33] && !io_direction_bit[`PX33]
		&& !open_drain_bit[`PX33] |=> pin_out[`PX33] == $past(port_latch[`PX33])
		&& pin_oe[`PX33]) // RULE20
		else $error("general port output broken");
	a_i2c_open_drain: assert property (@(posedge clk) disable iff (!nrst)
		pin_function_mode_bit[`PX40] && function_select_bit[`PX40] && od40
		|=> !pin_out[`PX40]) // RULE15
		else $error("i2c pin drives high");
	c_dac_on: cover property (@(posedge clk) disable iff (!nrst) dac_active_0 && dac_active_1);
	c_i2c_low: cover property (@(posedge clk) disable iff (!nrst) pin_oe[`PX38] && !pin_out[`PX38]);
	c_p50_rtp: cover property (@(posedge clk) disable iff (!nrst)
		pin_function_mode_bit[`PX50] && s50 == 2'h3);
	c_debug: cover property (@(posedge clk) disable iff (!nrst) debug_reset_in);
endmodule
`default_nettype wire

/* testbench/pin_pad_model.sv */
// pad model: resolves each package pin from the block's drive and an outside driver
// assumes the bench drives ext_level and ext_en just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module pin_pad_model (
	input  wire logic [23:0] pin_out,
	input  wire logic [23:0] pin_oe,
	input  wire logic [23:0] ext_level,
	input  wire logic [23:0] ext_en,
	output logic      [23:0] pin_in
);
	// ****
	// pad resolution
	// ****
	// a released pad floats to its pull-up, never to a held old value
	always_comb begin
		for (int i = 0; i < 24; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_level[i] : 1'b1);
		end
	end
endmodule
`default_nettype wire

/* testbench/port_alt_function_select_tb_top.sv */
// self-checking bench for the port alternate-function selector
// assumes the params header and pin_mux_pkg are compiled with the design
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_params.svh"
module port_alt_function_select_tb_top;
	import pin_mux_pkg::*;
	// ****
	// stimulus and expectation state
	// ****
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        dbg = 1'b0;
	pin_vec_t    mode = '0, fsel = '0, fext = '0, dir = '0, od = '0;
	pin_vec_t    latch = '0, ext = '0, ext_en = '0;
	logic [24:0] pv = '0;
	wire  [23:0] pin_out, pin_oe, port_in, pin_in;
	wire  [27:0] got;
	pin_vec_t    eo, eoe, lev, eport;
	logic [27:0] eper;
	int          checks = 0;
	int          num_errors = 0;
	int          cycles = 0;

	initial begin
		forever #4 clk = ~clk;
	end

	port_alt_function_select port_alt_function_select_inst (
		.clk(clk), .nrst(nrst), .pin_function_mode_bit(mode), .function_select_bit(fsel),
		.function_select_ext_bit(fext), .io_direction_bit(dir), .open_drain_bit(od),
		.port_latch(latch), .debug_pin_enable(dbg), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .port_in(port_in), .addr_bit_21(pv[0]), .rtc_one_hertz(pv[1]),
		.rtc_divided_out(pv[2]), .rtc_clock_out(pv[3]), .dac_out_0(pv[4]), .dac_out_1(pv[5]),
		.uart0_tx(pv[6]), .csi4_data_out(pv[7]), .csi4_clock_out(pv[8]), .csi4_clock_oe(pv[9]),
		.timer_p0_out0(pv[10]), .timer_p0_out1(pv[11]), .timer_p1_out0(pv[12]),
		.timer_p1_out1(pv[13]), .uart3_tx(pv[14]), .uart2_tx(pv[15]),
		.i2c0_data_drive_low(pv[16]), .i2c0_clock_drive_low(pv[17]),
		.i2c1_data_drive_low(pv[18]), .i2c1_clock_drive_low(pv[19]), .csi0_data_out(pv[20]),
		.csi0_clock_out(pv[21]), .csi0_clock_oe(pv[22]), .timer_q0_out1(pv[23]),
		.realtime_port_bit0(pv[24]), .nmi_in(got[0]), .ext_irq_0(got[1]),
		.adc_ext_trigger(got[2]), .ext_irq_1(got[3]), .ext_irq_2(got[4]),
		.debug_reset_in(got[5]), .ext_irq_3(got[6]), .uart0_rx(got[7]), .ext_irq_7(got[8]),
		.csi4_data_in(got[9]), .csi4_clock_in(got[10]), .uart0_baud_clock_in(got[11]),
		.timer_p0_in0(got[12]), .timer_p0_in1(got[13]), .timer_p1_in0(got[14]),
		.timer_p1_in1(got[15]), .uart3_rx(got[16]), .uart2_rx(got[17]), .i2c0_data_in(got[18]),
		.i2c0_clock_in(got[19]), .i2c1_data_in(got[20]), .i2c1_clock_in(got[21]),
		.csi0_data_in(got[22]), .csi0_clock_in(got[23]), .timer_q0_in1(got[24]),
		.key_return_0(got[25]), .dac_active_0(got[26]), .dac_active_1(got[27])
	);

	pin_pad_model pin_pad_model_inst (
		.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .ext_en(ext_en), .pin_in(pin_in)
	);

	// ****
	// prediction
	// ****
	task automatic drv(input int i, input logic v, input logic en);
		eo[i] = v;
		eoe[i] = en;
	endtask

	task automatic tap(input int b, input logic c, input int i);
		if (c) eper[b] = lev[i];
	endtask

	task automatic predict();
		logic [1:0] p3, p4, p32, p50;
		pin_vec_t   m, s, alt;
		m = mode & ~24'h000060;
		s = fsel;
		p3 = {fext[`PX03], s[`PX03]};
		p4 = {fext[`PX04], s[`PX04]};
		p32 = {fext[`PX32], s[`PX32]};
		p50 = {fext[`PX50], s[`PX50]};
		eo = '0;
		eoe = '0;
		for (int i = 0; i < 21; i++)
			if (!m[i] && !(i == `PX05 && dbg)) drv(i, latch[i], !dir[i] && !(od[i] && latch[i]));
		// dac pins in port mode drive the latch without an open-drain stage
		if (!dir[`PX10]) drv(`PX10, latch[`PX10], 1'b1);
		if (!dir[`PX11]) drv(`PX11, latch[`PX11], 1'b1);
		if (m[`PX02] && s[`PX02]) drv(`PX02, pv[0], 1'b1);
		if (m[`PX03] && p3 == 2'b11) drv(`PX03, pv[1], 1'b1);
		if (m[`PX04] && p4 == 2'b01) drv(`PX04, pv[2], 1'b1);
		if (m[`PX04] && p4 == 2'b10) drv(`PX04, pv[3], 1'b1);
		if (m[`PX30]) drv(`PX30, s[`PX30] ? pv[7] : pv[6], 1'b1);
		if (m[`PX32] && p32 == 2'b01) drv(`PX32, pv[8], pv[9]);
		if (m[`PX32] && p32 == 2'b11) drv(`PX32, pv[10], 1'b1);
		if (m[`PX33] && s[`PX33]) drv(`PX33, pv[11], 1'b1);
		if (m[`PX34] && s[`PX34]) drv(`PX34, pv[12], 1'b1);
		if (m[`PX35] && s[`PX35]) drv(`PX35, pv[13], 1'b1);
		if (m[`PX36]) drv(`PX36, pv[14], 1'b1);
		// i2c pins only ever pull low; a released high level comes from the pad
		if (m[`PX38]) drv(`PX38, s[`PX38] ? 1'b0 : pv[15], !s[`PX38] || pv[16] || !od[`PX38]);
		if (m[`PX39] && s[`PX39]) drv(`PX39, 1'b0, pv[17] || !od[`PX39]);
		if (m[`PX40] && s[`PX40]) drv(`PX40, 1'b0, pv[18] || !od[`PX40]);
		if (m[`PX41]) drv(`PX41, s[`PX41] ? 1'b0 : pv[20], !s[`PX41] || pv[19] || !od[`PX41]);
		if (m[`PX42]) drv(`PX42, pv[21], pv[22]);
		if (m[`PX50] && p50[1]) drv(`PX50, p50[0] ? pv[24] : pv[23], 1'b1);
		for (int i = 0; i < 24; i++)
			lev[i] = eoe[i] ? eo[i] : (ext_en[i] ? ext[i] : 1'b1);
		alt = m | (24'(dbg) << `PX05);
		eport = lev & ~alt;
		eper = 28'h03f0080;
		tap(0, m[`PX02] && !s[`PX02], `PX02);
		tap(1, m[`PX03] && p3 == 2'b00, `PX03);
		tap(2, m[`PX03] && p3 == 2'b01, `PX03);
		tap(3, m[`PX04] && p4 == 2'b00, `PX04);
		tap(4, m[`PX05] && !dbg, `PX05);
		tap(5, dbg, `PX05);
		tap(6, m[`PX06], `PX06);
		tap(7, m[`PX31] && !s[`PX31], `PX31);
		tap(8, m[`PX31] && !s[`PX31], `PX31);
		tap(9, m[`PX31] && s[`PX31], `PX31);
		tap(10, m[`PX32] && p32 == 2'b01, `PX32);
		tap(11, m[`PX32] && p32 == 2'b00, `PX32);
		tap(12, m[`PX32] && p32 == 2'b10, `PX32);
		tap(13, m[`PX33] && !s[`PX33], `PX33);
		tap(14, m[`PX34] && !s[`PX34], `PX34);
		tap(15, m[`PX35] && !s[`PX35], `PX35);
		tap(16, m[`PX37], `PX37);
		tap(17, m[`PX39] && !s[`PX39], `PX39);
		tap(18, m[`PX38] && s[`PX38], `PX38);
		tap(19, m[`PX39] && s[`PX39], `PX39);
		tap(20, m[`PX40] && s[`PX40], `PX40);
		tap(21, m[`PX41] && s[`PX41], `PX41);
		tap(22, m[`PX40] && !s[`PX40], `PX40);
		tap(23, m[`PX42], `PX42);
		tap(24, m[`PX50] && p50 == 2'b01, `PX50);
		tap(25, m[`PX50] && p50 == 2'b01, `PX50);
		eper[27:26] = {dir[`PX11], dir[`PX10]};
	endtask

	// ****
	// checking and driving
	// ****
	task automatic chk(input string what, input logic [27:0] exp, input logic [27:0] seen);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic run(input pin_vec_t mv, input pin_vec_t sv, input pin_vec_t ev, input logic d);
		pin_vec_t nd, nl, k;
		nd = 24'($urandom);
		nl = 24'($urandom);
		// a port pin beside an active dac output keeps its level
		if (nd[`PX10] != nd[`PX11]) nl[6:5] = latch[6:5];
		@(posedge clk);
		mode <= mv;
		fsel <= sv;
		fext <= ev;
		dbg <= d;
		dir <= nd;
		od <= 24'($urandom);
		latch <= nl;
		ext <= 24'($urandom);
		ext_en <= 24'($urandom);
		pv <= 25'($urandom);
		// pads follow the block's drive at once; drives and inputs register over two edges, so allow three
		repeat (3) @(posedge clk);
		@(negedge clk);
		predict();
		// dac pins in dac mode are left to the dac itself
		k = 24'h1fffff & ~({dir[`PX11], dir[`PX10]} << 5);
		chk("pin_oe", 28'(eoe & k), 28'(pin_oe & k));
		chk("pin_out", 28'(eo & eoe & k), 28'(pin_out & eoe & k));
		chk("port_in", 28'(eport & 24'h1fff9f), 28'(port_in & 24'h1fff9f));
		chk("periph_in", eper, got);
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			print_verdict();
		end
	end

	// ****
	// main sequence
	// ****
	initial begin
		void'($urandom(57901));
		repeat (12) @(posedge clk);
		@(negedge clk);
		chk("reset pin_oe", 28'h0, 28'(pin_oe));
		chk("reset port_in", 28'h0, 28'(port_in));
		chk("reset periph_in", 28'h03f0080, got);
		@(posedge clk);
		nrst <= 1'b1;
		$display("test reset done");
		run('1, '0, '0, 1'b0);
		run('1, '1, '1, 1'b0);
		run('1, '0, '1, 1'b0);
		run('1, '1, '0, 1'b0);
		run('0, '1, '1, 1'b1);
		run('1, '0, '0, 1'b1);
		$display("test directed done");
		repeat (300)
			run(24'($urandom), 24'($urandom), 24'($urandom), ($urandom % 4) == 0);
		$display("test random done");
		print_verdict();
	end
endmodule
`default_nettype wire
